// ==== inc/smba_pkg.sv ====
/*
  Shared constants and carrier types for the alert and critical-temperature block.
  Assumes a 16-bit register port with one-cycle strobes and a conversion engine outside.
*/
package smba_pkg;
  // ----------------------------------------------------------------
  // widths and fixed addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [6:0] OWN_SLAVE_ADDR = 7'h4c; // 100 1100, hard-wired
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c; // 000 1100, never a slave address
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ENH_CONFIG = 8'h01;
  localparam logic [ADDR_W-1:0] REG_FILT_COMP = 8'h02;
  localparam logic [ADDR_W-1:0] REG_ALERT_STATUS = 8'h03;
  localparam logic [ADDR_W-1:0] REG_CRIT_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CRIT_HYST = 8'h05;
  localparam logic [ADDR_W-1:0] REG_REMOTE_HIGH = 8'h06;
  localparam logic [ADDR_W-1:0] REG_REMOTE_LOW = 8'h07;
  localparam logic [ADDR_W-1:0] REG_LOCAL_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LOCAL_TEMP = 8'h09;
  localparam logic [ADDR_W-1:0] REG_REMOTE_TEMP = 8'h0a;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_ALERT_MASK_BIT = 0;
  localparam int CFG_CRIT_UNLOCK_BIT = 1;
  localparam int ENH_USF_BIT = 0;
  localparam int FC_ALERT_CFG_BIT = 0;
  localparam int ST_LOCAL_HIGH = 0;
  localparam int ST_REMOTE_LOW = 1;
  localparam int ST_REMOTE_HIGH = 2;
  localparam int ST_REMOTE_CRIT = 3;
  localparam int ST_DIODE_FAULT = 4;
  localparam int ST_CRIT_FLAG = 5;
  localparam int ST_BUSY = 7;
  localparam logic [7:0] ST_ALERT_SRC = 8'h0f; // all but busy, diode fault and critical flag
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CRIT_LIMIT_RST = 8'h55;
  localparam logic [7:0] CRIT_HYST_RST = 8'h0a;
  localparam logic [15:0] REMOTE_HIGH_RST = 16'h5500;
  localparam logic [15:0] REMOTE_LOW_RST = 16'h0000;
  localparam logic [7:0] LOCAL_HIGH_RST = 8'h46;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } smba_reg_req_t;
  typedef struct packed {
    logic signed [13:0] remote_eighths; // raw remote reading, 0.125 degree steps
    logic signed [9:0] local_deg;       // raw local reading, 1 degree steps
    logic diode_fault;
    logic busy;
    logic done;                         // one-cycle end-of-conversion pulse
  } smba_conv_t;
  typedef struct packed {
    logic out; // always low
    logic oe;  // high while pulling the line low
  } smba_od_t;
endpackage

// ==== logic/smba_alert_critical_temp_out_n.sv ====
/*
  Alert and critical-temperature logic of a remote-diode sensor with its bus slave front end.
  Assumes: the bus clock and data come from pins and are sampled by core_clk_in;
  conversion results arrive with a one-cycle done pulse; the register port strobes are one cycle.
*/
// Function
// - alert response read while alerting: send own address, then release alert
// - release alert and set mask only after whole address sent successfully, or on status read with alert configuration low and alert bits set
// - mask set keeps alert released until software clears it
// - acknowledge alert response address, shift out address checking each released bit
// - alert response address is 000 1100, never own slave address
// - answer alert response address only while alert configuration bit is low
// - mask and alert configuration low after reset; mask set disables alert
// - handshake stops pulling alert again for same condition
// - critical flag set above critical limit; critical output follows flag
// - critical flag clears at or below limit minus hysteresis, 1 degree resolution
// - critical limit locked to default until unlock bit set
// - format select picks signed or unsigned limit; comparisons span +255 to -256
// - bus clock input only, never driven, never stretched
// - fixed slave address 1001100, not alterable
// - temperatures readable only at local and remote temperature registers
// - temperatures left-justified 16-bit words, unused low bits zero
// - out-of-range temperatures saturate at full scale, never wrap
// - remote temperature and high limit 11-bit, 0.125 degree steps
// - out-of-limit reading sets status; unmasked non-busy, non-fault bits pull alert
// - status bits clear only on status read, set again if condition persists
// - alert and critical outputs only pull low or release
module smba_alert_critical_temp_out_n (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // register port
  input wire smba_pkg::smba_reg_req_t reg_req_in,
  output logic [smba_pkg::DATA_W-1:0] reg_rdata_out,
  // conversion results
  input wire smba_pkg::smba_conv_t conv_in,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // open-drain event pins
  output smba_pkg::smba_od_t alert_n_out,
  output smba_pkg::smba_od_t critical_temp_out_n_out
);
  import smba_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_TX, ST_HOST_ACK, ST_SKIP} smba_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clamp remote reading to the 11-bit field of the chosen format
  function automatic logic [10:0] clamp_remote(input logic signed [13:0] v, input logic unsigned_format_sel);
    logic [10:0] r;
    r = v[10:0];
    if (unsigned_format_sel) begin
      if (v < 14'sd0) r = 11'h000;
      else if (v > 14'sd2047) r = 11'h7ff;
    end else begin
      if (v < -14'sd1024) r = 11'h400;
      else if (v > 14'sd1023) r = 11'h3ff;
    end
    return r;
  endfunction

  // clamp local reading to signed 8 bits
  function automatic logic [7:0] clamp_local(input logic signed [9:0] v);
    logic [7:0] r;
    r = v[7:0];
    if (v < -10'sd128) r = 8'h80;
    else if (v > 10'sd127) r = 8'h7f;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  // three-stage shift of the pins
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  // accept a level once stages two and three agree
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2]) sda_reg <= sda_sync_reg[2];
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // bus events: start and stop are data edges while the clock stays high
  assign scl_rise = scl_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_reg & scl_prev_reg;
  assign bus_start = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  assign bus_stop = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic alert_mask_reg;
  logic crit_unlock_reg;
  logic usf_reg;
  logic alert_cfg_reg;
  logic [7:0] status_reg;
  logic [3:0] cond_reg;
  logic critical_status_flag;
  logic [7:0] critical_limit;
  logic [7:0] critical_hysteresis;
  logic [15:0] remote_high_reg;
  logic [15:0] remote_low_reg;
  logic [7:0] local_high_reg;
  logic [10:0] remote_word_reg;
  logic [7:0] local_word_reg;

  logic wr_cfg;
  logic rd_status;
  logic ara_ok;
  logic alert_pull;
  logic [7:0] status_set;

  assign wr_cfg = reg_req_in.wr && (reg_req_in.addr == REG_CONFIG);
  assign rd_status = reg_req_in.rd && (reg_req_in.addr == REG_ALERT_STATUS);

  // alert mask: hardware set beats a software clear in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      alert_mask_reg <= 1'b0;
    end else if (ara_ok) begin
      alert_mask_reg <= 1'b1;
    end else if (rd_status && !alert_cfg_reg && |(status_reg & ST_ALERT_SRC)) begin
      alert_mask_reg <= 1'b1;
    end else if (wr_cfg) begin
      alert_mask_reg <= reg_req_in.wdata[CFG_ALERT_MASK_BIT];
    end
  end

  // configuration bits written by software
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      crit_unlock_reg <= 1'b0;
      usf_reg <= 1'b0;
      alert_cfg_reg <= 1'b0;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == REG_CONFIG) crit_unlock_reg <= reg_req_in.wdata[CFG_CRIT_UNLOCK_BIT];
      if (reg_req_in.addr == REG_ENH_CONFIG) usf_reg <= reg_req_in.wdata[ENH_USF_BIT];
      if (reg_req_in.addr == REG_FILT_COMP) alert_cfg_reg <= reg_req_in.wdata[FC_ALERT_CFG_BIT];
    end
  end

  // limits; the critical limit ignores writes while locked
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      critical_limit <= CRIT_LIMIT_RST;
      critical_hysteresis <= CRIT_HYST_RST;
      remote_high_reg <= REMOTE_HIGH_RST;
      remote_low_reg <= REMOTE_LOW_RST;
      local_high_reg <= LOCAL_HIGH_RST;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == REG_CRIT_LIMIT && crit_unlock_reg) begin
        critical_limit <= reg_req_in.wdata[7:0];
      end
      if (reg_req_in.addr == REG_CRIT_HYST) critical_hysteresis <= reg_req_in.wdata[7:0];
      if (reg_req_in.addr == REG_REMOTE_HIGH) remote_high_reg <= {reg_req_in.wdata[15:5], 5'h00};
      if (reg_req_in.addr == REG_REMOTE_LOW) remote_low_reg <= {reg_req_in.wdata[15:5], 5'h00};
      if (reg_req_in.addr == REG_LOCAL_HIGH) local_high_reg <= reg_req_in.wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // limit comparison on each conversion
  // ----------------------------------------------------------------
  logic [10:0] remote_now;
  logic [7:0] local_now;
  logic signed [10:0] remote_int;
  logic signed [10:0] remote_deg;
  logic signed [10:0] limit_deg;
  logic signed [10:0] release_deg;
  logic above_high;
  logic below_low;

  always_comb begin
    remote_now = clamp_remote(conv_in.remote_eighths, usf_reg);
    local_now = clamp_local(conv_in.local_deg);
    remote_int = 11'(conv_in.remote_eighths >>> 3);
    // whole-degree reading held to +255 .. -256
    remote_deg = remote_int;
    if (remote_int > 11'sd255) remote_deg = 11'sd255;
    else if (remote_int < -11'sd256) remote_deg = -11'sd256;
    // limit widened as signed or unsigned by format select
    limit_deg = usf_reg ? $signed({3'h0, critical_limit}) : 11'($signed(critical_limit));
    release_deg = limit_deg - $signed({3'h0, critical_hysteresis});
    if (usf_reg) begin
      above_high = remote_now > remote_high_reg[15:5];
      below_low = remote_now < remote_low_reg[15:5];
    end else begin
      above_high = $signed(remote_now) > $signed(remote_high_reg[15:5]);
      below_low = $signed(remote_now) < $signed(remote_low_reg[15:5]);
    end
    status_set = 8'h00;
    if (conv_in.done) begin
      status_set[ST_LOCAL_HIGH] = $signed(local_now) > $signed(local_high_reg);
      status_set[ST_REMOTE_LOW] = below_low;
      status_set[ST_REMOTE_HIGH] = above_high;
      status_set[ST_REMOTE_CRIT] = remote_deg > limit_deg;
      status_set[ST_DIODE_FAULT] = conv_in.diode_fault;
    end
  end

  // sticky status: a read clears, a new set in the same cycle survives
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      status_reg <= 8'h00;
    end else begin
      status_reg <= ((rd_status ? 8'h00 : status_reg) | status_set) & 8'h1f;
    end
  end

  // live conditions for comparator mode, renewed each conversion
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      cond_reg <= 4'h0;
    end else if (conv_in.done) begin
      cond_reg <= status_set[3:0];
    end
  end

  // critical flag with hysteresis
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      critical_status_flag <= 1'b0;
    end else if (conv_in.done) begin
      if (remote_deg > limit_deg) critical_status_flag <= 1'b1;
      else if (remote_deg <= release_deg) critical_status_flag <= 1'b0;
    end
  end

  // latched readings
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      remote_word_reg <= 11'h000;
      local_word_reg <= 8'h00;
    end else if (conv_in.done) begin
      remote_word_reg <= remote_now;
      local_word_reg <= local_now;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        REG_CONFIG: reg_rdata_out <= {14'h0000, crit_unlock_reg, alert_mask_reg};
        REG_ENH_CONFIG: reg_rdata_out <= {15'h0000, usf_reg};
        REG_FILT_COMP: reg_rdata_out <= {15'h0000, alert_cfg_reg};
        REG_ALERT_STATUS: reg_rdata_out <= {8'h00, conv_in.busy, 1'b0, critical_status_flag, status_reg[4:0]};
        REG_CRIT_LIMIT: reg_rdata_out <= {8'h00, critical_limit};
        REG_CRIT_HYST: reg_rdata_out <= {8'h00, critical_hysteresis};
        REG_REMOTE_HIGH: reg_rdata_out <= remote_high_reg;
        REG_REMOTE_LOW: reg_rdata_out <= remote_low_reg;
        REG_LOCAL_HIGH: reg_rdata_out <= {8'h00, local_high_reg};
        REG_LOCAL_TEMP: reg_rdata_out <= {local_word_reg, 8'h00};
        REG_REMOTE_TEMP: reg_rdata_out <= {remote_word_reg, 5'h00};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // bus slave: address match, acknowledge, address transmit
  // ----------------------------------------------------------------
  smba_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ara_reg;
  logic rnw_reg;
  logic ara_hit;
  logic own_hit;
  logic tx_lost;

  assign ara_hit = (shift_reg[7:1] == ALERT_RESP_ADDR) && shift_reg[0] && alert_pull && !alert_cfg_reg;
  assign own_hit = shift_reg[7:1] == OWN_SLAVE_ADDR;
  assign tx_lost = scl_rise && shift_reg[7] && !sda_reg;
  assign ara_ok = (state_reg == ST_TX) && scl_rise && ara_reg && (bit_cnt_reg == 4'h7) && !tx_lost;

  // slave sequencer, stepped by sampled clock edges and by start and stop events
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ara_reg <= 1'b0;
      rnw_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= ST_IDLE;
    end else if (bus_start) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_SKIP: begin
        end
        ST_ADDR: begin
          if (scl_rise && bit_cnt_reg < 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            rnw_reg <= shift_reg[0];
            ara_reg <= ara_hit;
            state_reg <= (ara_hit || own_hit) ? ST_ACK : ST_SKIP;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= ara_reg ? {OWN_SLAVE_ADDR, 1'b0} : 8'hff;
            state_reg <= rnw_reg ? ST_TX : ST_SKIP;
          end
        end
        ST_TX: begin
          if (tx_lost) begin
            state_reg <= ST_SKIP;
          end else if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) state_reg <= ST_HOST_ACK;
            else shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        ST_HOST_ACK: begin
          if (scl_rise) state_reg <= ST_SKIP;
        end
      endcase
    end
  end

  // data pin pulls low only for acknowledge and zero bits; clock pin has no driver
  assign sda_out = 1'b0;
  assign sda_oe_out = (state_reg == ST_ACK) || (state_reg == ST_TX && !shift_reg[7]);

  // ----------------------------------------------------------------
  // event pins
  // ----------------------------------------------------------------
  // mask gates both modes; comparator mode follows live conditions
  assign alert_pull = !alert_mask_reg && (alert_cfg_reg ? |cond_reg : |(status_reg & ST_ALERT_SRC));
  assign alert_n_out.out = 1'b0;
  assign alert_n_out.oe = alert_pull;
  assign critical_temp_out_n_out.out = 1'b0;
  assign critical_temp_out_n_out.oe = critical_status_flag;
endmodule

// ==== test/smba_assertions.sv ====
/*
  Port checks for the alert and critical-temperature block.
  Assumes binding to smba_alert_critical_temp_out_n, rstn_in low while in reset.
*/
module smba_assertions (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rstn_in,
  // register port
  input wire smba_pkg::smba_reg_req_t reg_req_in,
  input wire logic [smba_pkg::DATA_W-1:0] reg_rdata_out,
  // conversion results
  input wire smba_pkg::smba_conv_t conv_in,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire smba_pkg::smba_od_t alert_n_out,
  input wire smba_pkg::smba_od_t critical_temp_out_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import smba_pkg::*;
  // ----
  // checks
  // ----
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  a_od_pull_only: assert property (
    !sda_out && !alert_n_out.out && !critical_temp_out_n_out.out)
    else $error("pin drives high");
  a_rdata_idle_zero: assert property (
    !$past(reg_req_in.rd) |-> reg_rdata_out == '0)
    else $error("read data outside read slot");
  a_unmapped_read_zero: assert property (
    reg_req_in.rd && reg_req_in.addr > REG_REMOTE_TEMP |=> reg_rdata_out == '0)
    else $error("unmapped read not zero");
  a_local_low_zero: assert property (
    reg_req_in.rd && reg_req_in.addr == REG_LOCAL_TEMP |=> reg_rdata_out[7:0] == 8'h00)
    else $error("local word low byte not zero");
  a_crit_rise_cause: assert property (
    $rose(critical_temp_out_n_out.oe) |-> $past(conv_in.done))
    else $error("critical pin set without conversion");
  a_crit_fall_cause: assert property (
    $fell(critical_temp_out_n_out.oe) |-> $past(conv_in.done))
    else $error("critical pin cleared without conversion");
  a_alert_rise_cause: assert property (
    $rose(alert_n_out.oe) |-> $past(conv_in.done) || $past(reg_req_in.wr))
    else $error("alert pulled without cause");
  a_mask_blocks_alert: assert property (
    reg_req_in.wr && reg_req_in.addr == REG_CONFIG && reg_req_in.wdata[CFG_ALERT_MASK_BIT]
    |=> !alert_n_out.oe)
    else $error("alert pulled while masked");
endmodule
bind smba_alert_critical_temp_out_n smba_assertions u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out), .conv_in(conv_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .alert_n_out(alert_n_out),
  .critical_temp_out_n_out(critical_temp_out_n_out));

// ==== test/smba_host_model.sv ====
/*
  Bus host model: makes the bus clock, runs one read transfer per call.
  Assumes a pulled-up data line whose level comes back on sda_in.
*/
module smba_host_model (
  // clock
  input wire logic clk_in,
  // bus pins
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // bit and transfer tasks
  // ----
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // data moves only while the clock is low, sampled mid high phase
  task automatic bitx(input logic pull, output logic s);
    repeat (2) @(posedge clk_in);
    sda_oe_out <= pull;
    repeat (6) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    s = sda_in;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask
  // start, address, ack, one byte, not-acknowledge, stop; jam pulls that byte bit low
  task automatic xfer(input logic [6:0] a, input logic rw, input int jam, output logic ack,
    output logic [7:0] d);
    logic [7:0] x;
    logic s;
    x = {a, rw};
    repeat (8) @(posedge clk_in);
    sda_oe_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    scl_out <= 1'b0;
    for (int i = 7; i >= 0; i--) bitx(!x[i], s);
    bitx(1'b0, s);
    ack = !s;
    for (int i = 7; i >= 0; i--) begin
      bitx(jam == 7 - i, s);
      d[i] = s;
    end
    bitx(1'b0, s);
    repeat (2) @(posedge clk_in);
    sda_oe_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (8) @(posedge clk_in);
    sda_oe_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// ==== test/tb.sv ====
/*
  Self-checking bench for the alert and critical-temperature block.
  Assumes the bound checker and the host model beside the design.
*/
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smba_pkg::*;
  typedef struct packed {
    logic signed [13:0] rem;
    logic signed [9:0] loc;
    logic [15:0] erem;
    logic [15:0] eloc;
    logic crit;
  } smba_row_t;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  smba_reg_req_t req = '0;
  smba_conv_t conv = '0;
  logic [15:0] rdata, d;
  logic scl, h_oe, sda_oe, sda_line, ack;
  logic [7:0] b;
  smba_od_t alert, crit;
  int bad_count = 0;
  int checks = 0;
  smba_row_t rows [8] = '{'{14'sd8, 10'sd25, 16'h0100, 16'h1900, 1'b0},
    '{-14'sd1, 10'sd25, 16'hffe0, 16'h1900, 1'b0}, '{14'sd686, 10'sd25, 16'h55c0, 16'h1900, 1'b0},
    '{14'sd688, 10'sd25, 16'h5600, 16'h1900, 1'b1}, '{14'sd608, 10'sd25, 16'h4c00, 16'h1900, 1'b1},
    '{14'sd600, 10'sd25, 16'h4b00, 16'h1900, 1'b0}, '{14'sd5000, 10'sd300, 16'h7fe0, 16'h7f00, 1'b1},
    '{-14'sd5000, -10'sd200, 16'h8000, 16'h8000, 1'b0}};
  // ----
  // clock, wired data line, instances
  // ----
  always #5 core_clk_in = ~core_clk_in;
  assign sda_line = !(h_oe || sda_oe);
  smba_alert_critical_temp_out_n dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .conv_in(conv), .scl_in(scl), .sda_in(sda_line), .sda_out(),
    .sda_oe_out(sda_oe), .alert_n_out(alert), .critical_temp_out_n_out(crit));
  smba_host_model host (.clk_in(core_clk_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(h_oe));
  // register and conversion drivers
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk_in);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge core_clk_in);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic cv(input logic signed [13:0] r, input logic signed [9:0] l);
    @(posedge core_clk_in);
    conv.remote_eighths <= r;
    conv.local_deg <= l;
    conv.done <= 1'b1;
    @(posedge core_clk_in);
    conv.done <= 1'b0;
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rd(REG_CONFIG);
    `CHK({d[1:0], alert.oe, crit.oe}, 4'h0)
    rd(REG_FILT_COMP);
    `CHK(d[0], 1'b0)
    rd(8'hff);
    `CHK(d, 16'h0000)
    foreach (rows[i]) begin
      cv(rows[i].rem, rows[i].loc);
      `CHK(crit.oe, rows[i].crit)
      rd(REG_REMOTE_TEMP);
      `CHK(d, rows[i].erem)
      rd(REG_LOCAL_TEMP);
      `CHK(d, rows[i].eloc)
    end
    `CHK(alert.oe, 1'b1)
    wr(REG_CRIT_LIMIT, 16'h0010);
    cv(14'sd320, 10'sd25);
    `CHK(crit.oe, 1'b0)
    wr(REG_CONFIG, 16'h0002);
    wr(REG_CRIT_LIMIT, 16'h0010);
    cv(14'sd320, 10'sd25);
    `CHK(crit.oe, 1'b1)
    wr(REG_CRIT_LIMIT, 16'h00c8);
    wr(REG_ENH_CONFIG, 16'h0001);
    cv(14'sd320, 10'sd25);
    `CHK(crit.oe, 1'b0)
    cv(14'sd1680, 10'sd25);
    rd(REG_REMOTE_TEMP);
    `CHK({crit.oe, d}, {1'b1, 16'hd200})
    host.xfer(7'h4d, 1'b1, 9, ack, b);
    `CHK(ack, 1'b0)
    host.xfer(OWN_SLAVE_ADDR, 1'b1, 9, ack, b);
    `CHK({ack, b}, 9'h1ff)
    host.xfer(ALERT_RESP_ADDR, 1'b1, 0, ack, b);
    rd(REG_CONFIG);
    `CHK({ack, alert.oe, d[0]}, 3'b110)
    host.xfer(ALERT_RESP_ADDR, 1'b1, 9, ack, b);
    rd(REG_CONFIG);
    `CHK({ack, b, alert.oe, d[0]}, {1'b1, 8'h98, 1'b0, 1'b1})
    cv(14'sd1680, 10'sd25);
    `CHK(alert.oe, 1'b0)
    wr(REG_CONFIG, 16'h0002);
    `CHK(alert.oe, 1'b1)
    wr(REG_FILT_COMP, 16'h0001);
    host.xfer(ALERT_RESP_ADDR, 1'b1, 9, ack, b);
    `CHK(ack, 1'b0)
    wr(REG_FILT_COMP, 16'h0000);
    wr(REG_CONFIG, 16'h0003);
    `CHK(alert.oe, 1'b0)
    rd(REG_ALERT_STATUS);
    `CHK(|d[3:0], 1'b1)
    rd(REG_ALERT_STATUS);
    `CHK(d[3:0], 4'h0)
    // diode fault and busy alone never pull the alert line
    wr(REG_CONFIG, 16'h0002);
    @(posedge core_clk_in);
    conv.diode_fault <= 1'b1;
    conv.busy <= 1'b1;
    cv(14'sd320, 10'sd25);
    `CHK({alert.oe, crit.oe}, 2'b00)
    rd(REG_ALERT_STATUS);
    `CHK(d, 16'h0090)
    // mid-run reset puts the limit lock and the mask back
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rd(REG_CRIT_LIMIT);
    `CHK(d, {8'h00, CRIT_LIMIT_RST})
    rd(REG_CONFIG);
    `CHK({d[1:0], alert.oe, crit.oe}, 4'h0)
    summarize();
  end
  // watchdog well past the expected run length
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule
